// *** hw/flash_fault_prot.sv ***
// Chosen here: the APB slave port.
`timescale 1ns/10ps
// How it works
// RULE1 - Double-bit read fault or collision with a busy block sets the double flag.
// RULE2 - Fault flags clear only by writing one; zero leaves them alone.
// RULE3 - With ignore bit clear, corrected single fault or collision sets single flag.
// RULE4 - A parity fault reports single or double, never both.
// RULE5 - A read colliding with a running command raises both flags; while the ignore bit is set the code raises only the double flag.
// RULE6 - Fault flags appear in the status register one cycle after the read; the code sets them two cycles after the read.
// RULE7 - Software waits one idle cycle after a read before checking flags.
// RULE8 - Upper six bits of the error register read zero, writes ignored.
// RULE9 - Protection writes are taken only if they grow the protected region.
// RULE10 - Protection register loads from the nonvolatile byte at reset.
// RULE11 - Program or erase at a protected address is refused and flagged.
// RULE12 - Whole-block erase is refused if any sector is protected.
// RULE13 - Polarity zero makes enabled ranges unprotected; one makes them protected.
// RULE14 - Software keeps the reserved nonvolatile bit erased.
// RULE15 - High disable bit switches the range ending at the top address.
// RULE16 - High size field is writable only while high disable is set.
// RULE17 - Low disable bit switches the range starting at address zero.
// RULE18 - Low size field is writable only while low disable is set.
// RULE19 - Software unprotects the top sector before reprogramming the byte.
// RULE20 - While violation flag is set, commands are refused; write one clears it.
// RULE21 - Low size field sits in the two lowest bits of protection.
module flash_fault_prot
   import flash_prot_pkg::*;
#(
   parameter int unsigned FLASH_BYTES  = 32768,
   parameter int unsigned SECTOR_BYTES = 512,
   parameter int unsigned LOW_UNIT     = 2048,
   parameter int unsigned HIGH_UNIT    = 2048
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic [7:0]        nv_protection_byte,
   input  wire read_event_t       read_event,
   input  wire cmd_req_t          cmd_req,
   output logic                   cmd_accept,
   output logic                   cmd_refused,
   output logic                   protection_violation_flag,
   output logic [1:0]             fault_flags,
   output logic [7:0]             protection_reg
);

   localparam int unsigned SECTORS = FLASH_BYTES / SECTOR_BYTES;

   // Addresses are fifteen bits wide, so the array size is fixed.
   initial begin
      if (FLASH_BYTES != 32768) begin
         $error("flash_fault_prot: array size must be 32768 bytes");
      end
      if (SECTOR_BYTES == 0 || FLASH_BYTES % SECTOR_BYTES != 0) begin
         $error("flash_fault_prot: sector size must divide the array");
      end
      if (LOW_UNIT == 0 || LOW_UNIT * 8 > FLASH_BYTES ||
          LOW_UNIT % SECTOR_BYTES != 0) begin
         $error("flash_fault_prot: unsupported low range unit");
      end
      if (HIGH_UNIT == 0 || HIGH_UNIT * 8 > FLASH_BYTES ||
          HIGH_UNIT % SECTOR_BYTES != 0) begin
         $error("flash_fault_prot: unsupported high range unit");
      end
   end

   // ---------------------------------------------------------------
   // Range arithmetic
   // ---------------------------------------------------------------
   // Range lengths double with each step of the size field.
   function automatic logic [16:0] low_len(input logic [7:0] p);
      low_len = 17'(LOW_UNIT) << p[PROT_LS_LSB +: 2]; // RULE21
   endfunction

   function automatic logic [16:0] high_len(input logic [7:0] p);
      high_len = 17'(HIGH_UNIT) << p[PROT_HS_LSB +: 2];
   endfunction

   // First byte of the high range, which always ends at the top address.
   function automatic logic [16:0] high_base(input logic [7:0] p);
      high_base = 17'(FLASH_BYTES) - high_len(p);
   endfunction

   // First byte address of sector i.
   function automatic logic [14:0] sector_base(input int unsigned i);
      sector_base = 15'(i * SECTOR_BYTES);
   endfunction

   // True when the given address cannot be programmed or erased.
   function automatic logic addr_protected(input logic [7:0]  p,
                                           input logic [14:0] a);
      logic in_low;
      logic in_high;
      logic in_any;
      in_low  = !p[PROT_LDIS_BIT] && {2'b00, a} < low_len(p); // RULE17
      in_high = !p[PROT_HDIS_BIT] &&
                {2'b00, a} >= high_base(p); // RULE15
      in_any  = in_low || in_high;
      addr_protected = p[PROT_POL_BIT] ? in_any : !in_any; // RULE13
   endfunction

   // True when any sector of the block is protected.
   function automatic logic any_protected(input logic [7:0] p);
      logic hit;
      hit = 1'b0;
      for (int unsigned i = 0; i < SECTORS; i++) begin
         if (addr_protected(p, sector_base(i))) begin
            hit = 1'b1;
         end
      end
      any_protected = hit;
   endfunction

   // True when every sector protected under cur stays protected under nxt.
   function automatic logic grows(input logic [7:0] cur,
                                  input logic [7:0] nxt);
      logic ok;
      ok = 1'b1;
      for (int unsigned i = 0; i < SECTORS; i++) begin
         if (addr_protected(cur, sector_base(i)) &&
             !addr_protected(nxt, sector_base(i))) begin
            ok = 1'b0;
         end
      end
      grows = ok;
   endfunction

   // ---------------------------------------------------------------
   // Register read data
   // ---------------------------------------------------------------
   // Word returned for a read of register index i.
   function automatic logic [31:0] read_word(input logic [5:0] i,
                                             input state_t     s);
      logic [31:0] w;
      w = RDATA_RESET;
      case (i)
         IDX_ERROR: begin
            w = {30'h0000_0000, s.err}; // RULE8
         end
         IDX_PROT: begin
            w = {24'h00_0000, s.prot};
         end
         IDX_CONFIG: begin
            w = {31'h0000_0000, s.ignore_sf};
         end
         IDX_MAIN_STATUS: begin
            w = 32'(s.viol) << STAT_VIOL_BIT;
         end
         default: begin
            w = RDATA_RESET;
         end
      endcase
      read_word = w;
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   state_t st;
   state_t next_st;

   logic [5:0]  idx;
   logic        mapped;
   logic        wr_done;
   logic        lane0;
   logic [7:0]  wbyte;
   logic [7:0]  prot_cand;
   logic        fault_single;
   logic        fault_double;
   logic        refuse;
   logic        access_first;
   logic        wr_error;
   logic        wr_prot;
   logic        wr_config;
   logic        wr_status;

   assign idx    = paddr[7:2];
   assign mapped = idx == IDX_ERROR ||
                   idx == IDX_PROT ||
                   idx == IDX_CONFIG ||
                   idx == IDX_MAIN_STATUS;
   assign wr_done = psel && penable && pwrite && st.pready && mapped && lane0;
   assign lane0  = pstrb[0];
   assign wbyte  = pwdata[7:0];
   // First access cycle of a transfer; the answer is launched from it.
   assign access_first = psel && penable && !st.pready;

   // ---------------------------------------------------------------
   // Register write strobes
   // ---------------------------------------------------------------
   // True in the cycle in which a write to register index target lands.
   function automatic logic reg_write(input logic       strobe,
                                      input logic [5:0] i,
                                      input logic [5:0] target);
      reg_write = strobe && i == target;
   endfunction

   assign wr_error  = reg_write(wr_done, idx, IDX_ERROR);
   assign wr_prot   = reg_write(wr_done, idx, IDX_PROT);
   assign wr_config = reg_write(wr_done, idx, IDX_CONFIG);
   assign wr_status = reg_write(wr_done, idx, IDX_MAIN_STATUS);

   // ---------------------------------------------------------------
   // Fault classification
   // ---------------------------------------------------------------
   always_comb begin
      fault_double = 1'b0;
      fault_single = 1'b0;
      // Double faults take precedence, so parity faults never raise both.
      if (read_event.valid) begin
         if (read_event.collision) begin
            fault_double = 1'b1; // RULE1 RULE5
            fault_single = !st.ignore_sf; // RULE3 RULE5
         end else if (read_event.double_fault) begin
            fault_double = 1'b1; // RULE1 RULE4
         end else if (read_event.single_fault) begin
            fault_single = !st.ignore_sf; // RULE3 RULE4
         end
      end
   end

   // ---------------------------------------------------------------
   // Protection write candidate
   // ---------------------------------------------------------------
   always_comb begin
      prot_cand = (st.prot & ~PROT_WR_MASK) | (wbyte & PROT_WR_MASK);
      if (!st.prot[PROT_HDIS_BIT]) begin
         prot_cand[PROT_HS_LSB +: 2] = st.prot[PROT_HS_LSB +: 2]; // RULE16
      end
      if (!st.prot[PROT_LDIS_BIT]) begin
         prot_cand[PROT_LS_LSB +: 2] = st.prot[PROT_LS_LSB +: 2]; // RULE18
      end
   end

   // ---------------------------------------------------------------
   // Command screening
   // ---------------------------------------------------------------
   always_comb begin
      refuse = 1'b0;
      // The violation flag blocks every command until software clears it.
      if (st.viol) begin
         refuse = 1'b1; // RULE20
      end else if (cmd_req.block_erase) begin
         refuse = any_protected(st.prot); // RULE12
      end else begin
         refuse = addr_protected(st.prot, cmd_req.addr); // RULE11
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st             = st;
      next_st.cmd_accept  = 1'b0;
      next_st.cmd_refused = 1'b0;

      // Until the byte is loaded no write or command may act on it.
      if (!st.loaded) begin
         next_st.prot   = nv_protection_byte; // RULE10
         next_st.loaded = 1'b1;
      end

      // Faults are staged for a cycle before reaching the flags.
      next_st.staged = {fault_double, fault_single}; // RULE6

      // A fault and a clear in the same cycle leave the flag set.
      if (wr_error) begin
         next_st.err = st.err & ~wbyte[1:0]; // RULE2 RULE8
      end
      next_st.err = next_st.err | st.staged; // RULE6

      if (wr_config) begin
         next_st.ignore_sf = wbyte[CFG_IGNORE_BIT];
      end

      // A write that would unprotect any sector is dropped as a whole.
      if (wr_prot && st.loaded && grows(st.prot, prot_cand)) begin
         next_st.prot = prot_cand; // RULE9
      end

      if (wr_status && wbyte[STAT_VIOL_BIT]) begin
         next_st.viol = 1'b0; // RULE20
      end

      // A refusal wins over a clear written in the same cycle.
      if (cmd_req.valid && st.loaded) begin
         if (refuse) begin
            next_st.cmd_refused = 1'b1;
            next_st.viol        = 1'b1; // RULE11
         end else begin
            next_st.cmd_accept = 1'b1;
         end
      end else if (cmd_req.valid) begin
         next_st.cmd_refused = 1'b1;
      end

      // APB: ready is raised in the second access cycle.
      next_st.pready  = access_first;
      next_st.pslverr = access_first && !mapped;
      if (access_first) begin
         next_st.prdata = read_word(idx, st);
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.err         <= ERR_RESET;
         st.staged      <= ERR_RESET;
         st.ignore_sf   <= IGNORE_RESET;
         st.prot        <= PROT_RESET;
         st.loaded      <= 1'b0;
         st.viol        <= 1'b0;
         st.pready      <= 1'b0;
         st.pslverr     <= 1'b0;
         st.prdata      <= RDATA_RESET;
         st.cmd_accept  <= 1'b0;
         st.cmd_refused <= 1'b0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign pready                    = st.pready;
   assign prdata                    = st.prdata;
   assign pslverr                   = st.pslverr;
   assign cmd_accept                = st.cmd_accept;
   assign cmd_refused               = st.cmd_refused;
   assign protection_violation_flag = st.viol;
   assign fault_flags               = st.err;
   assign protection_reg            = st.prot;

endmodule

// *** hw/flash_prot_pkg.sv ***
package flash_prot_pkg;

   // ---------------------------------------------------------------
   // Bus geometry and register indices (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W          = 8;
   localparam logic [5:0]  IDX_ERROR       = 6'h07;
   localparam logic [5:0]  IDX_PROT        = 6'h08;
   localparam logic [5:0]  IDX_CONFIG      = 6'h10;
   localparam logic [5:0]  IDX_MAIN_STATUS = 6'h11;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned ERR_SINGLE_BIT  = 0;
   localparam int unsigned ERR_DOUBLE_BIT  = 1;
   localparam int unsigned CFG_IGNORE_BIT  = 0;
   localparam int unsigned STAT_VIOL_BIT   = 4;
   localparam int unsigned PROT_POL_BIT    = 7;
   localparam int unsigned PROT_RSV_BIT    = 6;
   localparam int unsigned PROT_HDIS_BIT   = 5;
   localparam int unsigned PROT_HS_LSB     = 3;
   localparam int unsigned PROT_LDIS_BIT   = 2;
   localparam int unsigned PROT_LS_LSB     = 0;
   localparam logic [7:0]  PROT_WR_MASK    = 8'hbf;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [1:0]  ERR_RESET       = 2'h0;
   localparam logic [7:0]  PROT_RESET      = 8'hff;
   localparam logic        IGNORE_RESET    = 1'b0;
   localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        single_fault;
      logic        double_fault;
      logic        collision;
   } read_event_t;

   typedef struct packed {
      logic        valid;
      logic        block_erase;
      logic [14:0] addr;
   } cmd_req_t;

   typedef struct packed {
      logic [1:0]  err;
      logic [1:0]  staged;
      logic        ignore_sf;
      logic [7:0]  prot;
      logic        loaded;
      logic        viol;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        cmd_accept;
      logic        cmd_refused;
   } state_t;

endpackage

// *** tb/flash_fault_prot_props.sv ***
`timescale 1ns/10ps
module flash_fault_prot_props
   import flash_prot_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic [7:0]        nv_protection_byte,
   input wire read_event_t       read_event,
   input wire cmd_req_t          cmd_req,
   input wire logic              cmd_refused,
   input wire logic              protection_violation_flag,
   input wire logic [1:0]        fault_flags,
   input wire logic [7:0]        protection_reg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire          wr_err = psel && penable && pready && pwrite
                          && paddr[7:2] == IDX_ERROR && pstrb[0];
   wire          ev_d   = ce && read_event.valid
                          && (read_event.double_fault || read_event.collision);
   property p_delay;
      ev_d && !fault_flags[1] |-> ##1 !fault_flags[1] ##1 fault_flags[1];
   endproperty
   a_delay: assert property (p_delay) else $error("double flag timing");
   property p_excl;
      ce && read_event == 4'b1110 && fault_flags == 2'h0
      |-> ##2 fault_flags == 2'h2;
   endproperty
   a_excl: assert property (p_excl) else $error("both flags on parity");
   property p_clr_s;
      $fell(fault_flags[0]) |-> $past(wr_err && pwdata[0]);
   endproperty
   a_clr_s: assert property (p_clr_s) else $error("single flag lost");
   property p_clr_d;
      $fell(fault_flags[1]) |-> $past(wr_err && pwdata[1]);
   endproperty
   a_clr_d: assert property (p_clr_d) else $error("double flag lost");
   property p_rsv;
      pready && !pwrite && paddr[7:2] == IDX_ERROR |-> prdata[31:2] == 30'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("error upper bits set");
   property p_wait;
      $rose(penable) && psel && ce |-> !pready ##1 pready;
   endproperty
   a_wait: assert property (p_wait) else $error("apb wait state");
   property p_hs;
      $changed(protection_reg[4:3]) |-> $past(protection_reg[5]);
   endproperty
   a_hs: assert property (p_hs) else $error("high size changed");
   property p_ls;
      $changed(protection_reg[1:0]) |-> $past(protection_reg[2]);
   endproperty
   a_ls: assert property (p_ls) else $error("low size changed");
   property p_load;
      $rose(presetn) |-> ##1 protection_reg == $past(nv_protection_byte);
   endproperty
   a_load: assert property (p_load) else $error("protection not loaded");
   property p_block;
      ce && cmd_req.valid && protection_violation_flag |-> ##1 cmd_refused;
   endproperty
   a_block: assert property (p_block) else $error("command not blocked");
   property p_flag;
      cmd_refused |-> protection_violation_flag;
   endproperty
   a_flag: assert property (p_flag) else $error("refusal without flag");
   c_refused: cover property (cmd_refused);
   c_both: cover property (fault_flags == 2'h3);
   c_slverr: cover property (pready && pslverr);
endmodule

bind flash_fault_prot flash_fault_prot_props u_flash_fault_prot_props (
   .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pstrb, .pready, .prdata, .pslverr, .nv_protection_byte, .read_event,
   .cmd_req, .cmd_refused, .protection_violation_flag, .fault_flags,
   .protection_reg
);

// *** tb/flash_fault_prot_tb.sv ***
`timescale 1ns/10ps
module flash_fault_prot_tb
   import flash_prot_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, ce;
   logic        pready, pslverr, cmd_accept, cmd_refused, viol;
   logic [7:0]  paddr, prot, nv_byte;
   logic [31:0] pwdata, prdata;
   logic [1:0]  fault_flags;
   read_event_t read_event;
   cmd_req_t    cmd_req;
   logic [32:0] rq[$];
   logic [1:0]  cq[$];
   int          err_count, n_compared, cyc;
   integer      seed = 32'h59110160;
   logic [2:0]  evt [4] = '{3'b100, 3'b010, 3'b110, 3'b001};
   logic [1:0]  fx [2][4] = '{'{2'h1, 2'h2, 2'h2, 2'h3},
                              '{2'h0, 2'h2, 2'h2, 2'h2}};

   flash_fault_prot u_flash_fault_prot (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .nv_protection_byte(nv_byte),
      .read_event(read_event), .cmd_req(cmd_req),
      .cmd_accept(cmd_accept), .cmd_refused(cmd_refused),
      .protection_violation_flag(viol), .fault_flags(fault_flags),
      .protection_reg(prot)
   );

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ------------------------------------------------------------
   // Bus and event drivers
   // ------------------------------------------------------------
   task automatic apb(logic w, logic [5:0] i, logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [5:0] i, logic [31:0] d);
      apb(1'b1, i, d);
   endtask
   task automatic rd(logic [5:0] i, logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, i, 32'h0);
   endtask
   task automatic cmd(logic b, logic [14:0] a, logic [1:0] e);
      @(posedge pclk);
      cmd_req <= {1'b1, b, a};
      cq.push_back(e);
      @(posedge pclk);
      cmd_req <= '0;
   endtask
   task automatic ev(logic [2:0] e);
      repeat ($random(seed) & 3) @(posedge pclk);
      @(posedge pclk);
      read_event <= {1'b1, e};
      @(posedge pclk);
      read_event <= '0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic chk(string nm, logic [32:0] s, logic [32:0] e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   always @(negedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         chk("read", {pslverr, prdata}, rq.pop_front());
      end
      if (cmd_accept === 1'b1 || cmd_refused === 1'b1) begin
         chk("cmd", {cmd_accept, cmd_refused}, cq.pop_front());
      end
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         report_and_stop();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      read_event = '0;
      cmd_req = '0;
      ce = 1'b1;
      nv_byte = 8'hff;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_PROT, 33'hff);
      rd(6'h00, 33'h1_0000_0000);
      cmd(1'b0, 15'h0000, 2'b10);
      nv_byte <= 8'hc7;
      wr(IDX_PROT, 32'hf9);
      rd(IDX_PROT, 33'hf9);
      wr(IDX_PROT, 32'hf8);
      wr(IDX_PROT, 32'hfd);
      rd(IDX_PROT, 33'hf9);
      cmd(1'b0, 15'h0fff, 2'b01);
      cmd(1'b0, 15'h2000, 2'b01);
      rd(IDX_MAIN_STATUS, 33'h10);
      wr(IDX_MAIN_STATUS, 32'h10);
      cmd(1'b0, 15'h1000, 2'b10);
      cmd(1'b1, 15'h7000, 2'b01);
      wr(IDX_MAIN_STATUS, 32'h10);
      wr(IDX_PROT, 32'h7d);
      cmd(1'b0, 15'($random(seed)), 2'b01);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(IDX_MAIN_STATUS, 33'h0);
      rd(IDX_PROT, 33'hc7);
      wr(IDX_PROT, 32'hc7);
      wr(IDX_PROT, 32'hd7);
      rd(IDX_PROT, 33'hc7);
      cmd(1'b0, 15'h77ff, 2'b10);
      cmd(1'b0, 15'h7800, 2'b01);
      for (int g = 0; g < 2; g++) begin
         wr(IDX_CONFIG, 32'(g));
         for (int k = 0; k < 4; k++) begin
            ev(evt[k]);
            rd(IDX_ERROR, 33'(fx[g][k]));
            wr(IDX_ERROR, 32'hfc);
            rd(IDX_ERROR, 33'(fx[g][k]));
            wr(IDX_ERROR, 32'h3);
            rd(IDX_ERROR, 33'h0);
         end
      end
      ce <= 1'b0;
      ev(3'b010);
      ce <= 1'b1;
      rd(IDX_ERROR, 33'h0);
      repeat (3) @(posedge pclk);
      report_and_stop();
   end
endmodule
